/* File: src/mado_pkg.sv */
// Constants for the debug override register bank of the motor algorithm.
// Assumes a register write port delivering offset, 32-bit data and a write strobe.
package mado_pkg;
	localparam logic [7:0] ADDR_DEBUG_OVR = 8'hEC;
	localparam logic [7:0] ADDR_DEV_CTRL = 8'hEA;
	localparam logic [31:0] RESET_DEBUG_OVR = 32'h0000_0000;
	localparam int BIT_SPEED_OVR = 31;
	localparam int SPEED_MSB = 30;
	localparam int SPEED_LSB = 16;
	localparam int BIT_OPEN_LOOP = 15;
	localparam int BIT_HOLD_ALIGN = 14;
	localparam int BIT_HOLD_SLOW = 13;
	localparam int BIT_HOLD_POS = 12;
	localparam int BIT_HOLD_SPD = 11;
	localparam int BIT_ANGLE_SRC = 10;
	localparam int IQ_MSB = 9;
	localparam int ANGLE_MSB = 19;
	localparam int ANGLE_LSB = 11;
	localparam logic [9:0] IQ_POS_LIMIT = 10'h1F4;
	localparam logic [9:0] IQ_NEG_START = 10'h200;
	localparam logic [10:0] IQ_WRAP = 11'h400;
	localparam logic [8:0] DEG_FULL_TURN = 9'h168;
	typedef enum logic [1:0] {
		MADO_START_ALIGN,
		MADO_START_DOUBLE_ALIGN,
		MADO_START_SLOW_CYCLE,
		MADO_START_POS_DETECT
	} mado_startup_t;
endpackage

/* File: src/mado_angle_mod.sv */
// Reduces a 9-bit degree value modulo 360.
// Assumes a plain unsigned input.
`timescale 1ns/10ps
module mado_angle_mod (
	input wire logic [8:0] deg_in,
	output logic [8:0] deg_out
);
	always_comb begin
		// One subtraction suffices: 9 bits cannot reach 720
		if (deg_in >= mado_pkg::DEG_FULL_TURN) begin
			deg_out = deg_in - mado_pkg::DEG_FULL_TURN;
		end else begin
			deg_out = deg_in;
		end
	end
endmodule // mado_angle_mod

/* File: src/mado_iq_decode.sv */
// Decodes the 10-bit torque reference code into a signed numerator over 500.
// Assumes the host only writes legal codes; codes 501 to 511 decode to zero, codes 1001 and up to code minus 1024.
`timescale 1ns/10ps
module mado_iq_decode (
	input wire logic [9:0] code,
	output logic signed [10:0] num,
	output logic code_legal
);
	always_comb begin
		num = 11'sh000;
		code_legal = 1'b0;
		if (code <= mado_pkg::IQ_POS_LIMIT) begin
			num = $signed({1'b0, code});
			code_legal = 1'b1;
		end else if (code >= mado_pkg::IQ_NEG_START) begin
			num = $signed({1'b0, code}) - $signed(mado_pkg::IQ_WRAP);
			// Codes 512 to 1000 map to -512 .. -24; 1001 and up are reserved
			code_legal = (num <= -11'sd24);
		end
	end
endmodule // mado_iq_decode

/* File: src/mado_debug_overrides.sv */
// Write-only debug override register and the selections it drives.
// Assumes synchronous write port and a loop-update strobe from the control core.
`timescale 1ns/10ps
module mado_debug_overrides (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] WR_ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic LOOP_UPDATE,
	input wire logic [14:0] ANALOG_SPEED,
	input wire logic [8:0] CFG_ALIGN_ANGLE,
	input wire logic [1:0] STARTUP_METHOD,
	input wire logic SPEED_DETECT_ENABLE,
	input wire logic SPEED_REGULATOR_OFF,
	input wire logic IN_ALIGN,
	input wire logic IN_SLOW_CYCLE,
	input wire logic IN_POS_DETECT,
	input wire logic IN_SPEED_DETECT,
	output logic [14:0] SPEED_CMD,
	output logic OPEN_LOOP_SELECT,
	output logic HOLD_ALIGN,
	output logic HOLD_SLOW_CYCLE,
	output logic HOLD_POSITION_DETECT,
	output logic HOLD_SPEED_DETECT,
	output logic [8:0] ALIGN_ANGLE,
	output logic signed [10:0] TORQUE_REF_NUM,
	output logic TORQUE_REF_ACTIVE,
	output logic TORQUE_CODE_LEGAL
);
	//------------------------------------------------------------
	// Register write
	//------------------------------------------------------------
	logic [31:0] ovr_reg;
	logic [31:0] ovr_next;
	logic [8:0] forced_angle_reg;
	logic [8:0] forced_angle_next;

	always_comb begin
		ovr_next = ovr_reg;
		forced_angle_next = forced_angle_reg;
		if (WR_EN && WR_ADDR == mado_pkg::ADDR_DEBUG_OVR) begin
			ovr_next = WR_DATA;
		end
		if (WR_EN && WR_ADDR == mado_pkg::ADDR_DEV_CTRL) begin
			forced_angle_next = WR_DATA[mado_pkg::ANGLE_MSB:mado_pkg::ANGLE_LSB];
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ovr_reg <= mado_pkg::RESET_DEBUG_OVR;
			forced_angle_reg <= 9'h000;
		end else begin
			ovr_reg <= ovr_next;
			forced_angle_reg <= forced_angle_next;
		end
	end

	//------------------------------------------------------------
	// Combinational selections
	//------------------------------------------------------------
	logic [8:0] forced_angle_mod;
	logic signed [10:0] iq_num;
	logic iq_legal;
	logic [14:0] speed_sel;
	logic [8:0] angle_sel;
	logic align_start;
	logic hold_align_sel;
	logic hold_slow_sel;
	logic hold_pos_sel;
	logic hold_spd_sel;

	mado_angle_mod u_angle (
		.deg_in(forced_angle_reg),
		.deg_out(forced_angle_mod)
	);

	mado_iq_decode u_iq (
		.code(ovr_reg[mado_pkg::IQ_MSB:0]),
		.num(iq_num),
		.code_legal(iq_legal)
	);

	always_comb begin
		if (ovr_reg[mado_pkg::BIT_SPEED_OVR]) begin
			speed_sel = ovr_reg[mado_pkg::SPEED_MSB:mado_pkg::SPEED_LSB];
		end else begin
			speed_sel = ANALOG_SPEED;
		end
		if (ovr_reg[mado_pkg::BIT_ANGLE_SRC]) begin
			angle_sel = forced_angle_mod;
		end else begin
			angle_sel = CFG_ALIGN_ANGLE;
		end
		align_start = (STARTUP_METHOD == mado_pkg::MADO_START_ALIGN)
			|| (STARTUP_METHOD == mado_pkg::MADO_START_DOUBLE_ALIGN);
		hold_align_sel = ovr_reg[mado_pkg::BIT_HOLD_ALIGN] && align_start;
		hold_slow_sel = ovr_reg[mado_pkg::BIT_HOLD_SLOW]
			&& (STARTUP_METHOD == mado_pkg::MADO_START_SLOW_CYCLE);
		hold_pos_sel = ovr_reg[mado_pkg::BIT_HOLD_POS]
			&& (STARTUP_METHOD == mado_pkg::MADO_START_POS_DETECT);
		hold_spd_sel = ovr_reg[mado_pkg::BIT_HOLD_SPD] && SPEED_DETECT_ENABLE;
	end

	//------------------------------------------------------------
	// Outputs latched at loop update
	//------------------------------------------------------------
	// Latching on the loop strobe keeps a command stable within one control period.
	logic [14:0] speed_reg;
	logic [14:0] speed_next;
	logic open_reg;
	logic open_next;
	logic [3:0] hold_reg;
	logic [3:0] hold_next;
	logic [8:0] angle_reg;
	logic [8:0] angle_next;
	logic signed [10:0] iq_reg;
	logic signed [10:0] iq_next;
	logic iq_act_reg;
	logic iq_act_next;
	logic legal_reg;
	logic legal_next;

	always_comb begin
		speed_next = speed_reg;
		open_next = open_reg;
		hold_next = hold_reg;
		angle_next = angle_reg;
		iq_next = iq_reg;
		iq_act_next = iq_act_reg;
		legal_next = legal_reg;
		if (LOOP_UPDATE) begin
			speed_next = speed_sel;
			open_next = ovr_reg[mado_pkg::BIT_OPEN_LOOP];
			hold_next = {hold_align_sel, hold_slow_sel, hold_pos_sel, hold_spd_sel};
			angle_next = angle_sel;
			iq_act_next = SPEED_REGULATOR_OFF;
			iq_next = SPEED_REGULATOR_OFF ? iq_num : 11'sh000;
			legal_next = iq_legal;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			speed_reg <= 15'h0000;
			open_reg <= 1'b0;
			hold_reg <= 4'h0;
			angle_reg <= 9'h000;
			iq_reg <= 11'sh000;
			iq_act_reg <= 1'b0;
			legal_reg <= 1'b1;
		end else begin
			speed_reg <= speed_next;
			open_reg <= open_next;
			hold_reg <= hold_next;
			angle_reg <= angle_next;
			iq_reg <= iq_next;
			iq_act_reg <= iq_act_next;
			legal_reg <= legal_next;
		end
	end

	assign SPEED_CMD = speed_reg;
	assign OPEN_LOOP_SELECT = open_reg;
	assign HOLD_ALIGN = hold_reg[3];
	assign HOLD_SLOW_CYCLE = hold_reg[2];
	assign HOLD_POSITION_DETECT = hold_reg[1];
	assign HOLD_SPEED_DETECT = hold_reg[0];
	assign ALIGN_ANGLE = angle_reg;
	assign TORQUE_REF_NUM = iq_reg;
	assign TORQUE_REF_ACTIVE = iq_act_reg;
	assign TORQUE_CODE_LEGAL = legal_reg;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence s_write_ovr;
		WR_EN && WR_ADDR == mado_pkg::ADDR_DEBUG_OVR;
	endsequence

	sequence s_update;
		LOOP_UPDATE;
	endsequence

	a_speed_override: assert property (@(posedge CLK) disable iff (RST)
		s_update ##1 1'b1 |-> SPEED_CMD == ($past(ovr_reg[31]) ?
		$past(ovr_reg[30:16]) : $past(ANALOG_SPEED)))
		else $error("speed command source wrong");
	a_speed_value: assert property (@(posedge CLK) disable iff (RST)
		s_write_ovr ##1 (LOOP_UPDATE && ovr_reg[31]) |=> SPEED_CMD == $past(ovr_reg[30:16], 1))
		else $error("digital speed not applied");
	a_open_loop: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE |=> OPEN_LOOP_SELECT == $past(ovr_reg[15]))
		else $error("open loop select wrong");
	a_hold_align: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE && ovr_reg[14] && STARTUP_METHOD <= 2'h1 |=> HOLD_ALIGN)
		else $error("align hold missing");
	a_hold_slow: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE |=> HOLD_SLOW_CYCLE == $past(ovr_reg[13] && STARTUP_METHOD == 2'h2))
		else $error("slow cycle hold wrong");
	a_hold_pos: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE |=> HOLD_POSITION_DETECT == $past(ovr_reg[12] && STARTUP_METHOD == 2'h3))
		else $error("position hold wrong");
	a_hold_spd: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE |=> HOLD_SPEED_DETECT == $past(ovr_reg[11] && SPEED_DETECT_ENABLE))
		else $error("speed detect hold wrong");
	a_angle_src: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE && !ovr_reg[10] |=> ALIGN_ANGLE == $past(CFG_ALIGN_ANGLE))
		else $error("align angle source wrong");
	a_angle_range: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE && ovr_reg[10] |=> ALIGN_ANGLE < 9'h168)
		else $error("forced angle not reduced");
	a_iq_gate: assert property (@(posedge CLK) disable iff (RST)
		!TORQUE_REF_ACTIVE |-> TORQUE_REF_NUM == 11'sh000)
		else $error("torque ref leaks while regulator on");
	a_iq_sign: assert property (@(posedge CLK) disable iff (RST)
		LOOP_UPDATE && SPEED_REGULATOR_OFF && ovr_reg[9:0] >= 10'h200
		|=> TORQUE_REF_NUM < 0)
		else $error("negative code not negative");
	a_reset_zero: assert property (@(posedge CLK)
		$fell(RST) |-> ovr_reg == 32'h0000_0000)
		else $error("register not cleared by reset");
	a_hold_steady: assert property (@(posedge CLK) disable iff (RST)
		!LOOP_UPDATE |=> $stable(SPEED_CMD) && $stable(OPEN_LOOP_SELECT))
		else $error("output moved without loop update");
endmodule // mado_debug_overrides

/* File: sim/mado_host_model.sv */
// Host controller model: issues register writes on the management port.
// Assumes the block samples a write on the rising CLK edge with WR_EN high.
`timescale 1ns/10ps
module mado_host_model (
	input wire logic CLK,
	output logic [7:0] WR_ADDR,
	output logic [31:0] WR_DATA,
	output logic WR_EN
);
	initial begin
		WR_ADDR = 8'h00;
		WR_DATA = 32'h0000_0000;
		WR_EN = 1'b0;
	end
	// ----------------------------------------
	// One write, one cycle
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit bad);
		logic [31:0] v;
		logic [9:0] c;
		v = d;
		c = d[9:0];
		// Only a scenario that asks for it may send a reserved torque code
		if (!bad && a == mado_pkg::ADDR_DEBUG_OVR && !(c <= 10'h1F4 || (c >= 10'h200 && c <= 10'h3E8))) begin
			v[9:0] = 10'h000;
		end
		@(posedge CLK);
		WR_ADDR <= a;
		WR_DATA <= v;
		WR_EN <= 1'b1;
		@(posedge CLK);
		WR_EN <= 1'b0;
		// Released bus shows garbage, never the stale value
		WR_ADDR <= ~a;
		WR_DATA <= ~v;
	endtask
endmodule // mado_host_model

/* File: sim/tb.sv */
// Self-checking bench for the debug override register bank.
// Assumes outputs settle one cycle after a LOOP_UPDATE pulse.
`timescale 1ns/10ps
module tb;
	logic CLK = 1'b0, RST = 1'b1, LOOP_UPDATE = 1'b0, sde = 1'b0, off = 1'b0, lu1 = 1'b0, lu2 = 1'b0;
	logic [7:0] WR_ADDR;
	logic [31:0] WR_DATA, dbg = 32'h0000_0000;
	logic WR_EN, ol, ha, hs, hp, hd, act, leg;
	logic [14:0] an = 15'h0000, spd;
	logic [8:0] cfg = 9'h000, fa = 9'h000, ang;
	logic [1:0] sm = 2'h0;
	logic [3:0] inst = 4'h0;
	logic [15:0] rnd = 16'h001A;
	logic signed [10:0] num;
	logic [41:0] q[$], obs, lastexp;
	int error_cnt = 0, samples_checked = 0;
	localparam logic [7:0] EC = mado_pkg::ADDR_DEBUG_OVR;
	assign obs = {spd, ol, ha, hs, hp, hd, ang, num, act, leg};
	always #5 CLK = ~CLK;
	mado_host_model i_host (.CLK(CLK), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN));
	mado_debug_overrides i_dut (.CLK(CLK), .RST(RST), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
		.WR_EN(WR_EN), .LOOP_UPDATE(LOOP_UPDATE), .ANALOG_SPEED(an), .CFG_ALIGN_ANGLE(cfg),
		.STARTUP_METHOD(sm), .SPEED_DETECT_ENABLE(sde), .SPEED_REGULATOR_OFF(off),
		.IN_ALIGN(inst[0]), .IN_SLOW_CYCLE(inst[1]), .IN_POS_DETECT(inst[2]),
		.IN_SPEED_DETECT(inst[3]), .SPEED_CMD(spd), .OPEN_LOOP_SELECT(ol), .HOLD_ALIGN(ha),
		.HOLD_SLOW_CYCLE(hs), .HOLD_POSITION_DETECT(hp), .HOLD_SPEED_DETECT(hd),
		.ALIGN_ANGLE(ang), .TORQUE_REF_NUM(num), .TORQUE_REF_ACTIVE(act),
		.TORQUE_CODE_LEGAL(leg));
	// ----------------------------------------
	// Reference model and helpers
	// ----------------------------------------
	function automatic logic [15:0] nx(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [41:0] expv();
		logic [9:0] c;
		logic ok;
		c = dbg[9:0];
		ok = c <= 10'h1F4 || (c >= 10'h200 && c <= 10'h3E8);
		return {dbg[31] ? dbg[30:16] : an, dbg[15], dbg[14] && sm < 2'h2,
			dbg[13] && sm == 2'h2, dbg[12] && sm == 2'h3, dbg[11] && sde,
			dbg[10] ? (fa >= 9'h168 ? fa - 9'h168 : fa) : cfg,
			!off ? 11'h000 : (c <= 10'h1F4 ? {1'b0, c} :
			(c >= 10'h200 ? {1'b0, c} - 11'h400 : 11'h000)),
			off, ok};
	endfunction
	task automatic chk(string n, logic [41:0] e, logic [41:0] s);
		samples_checked++;
		if (e !== s) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(logic [7:0] a, logic [31:0] d, bit bad = 0);
		i_host.wr(a, d, bad);
		if (a == EC) dbg = d;
		if (a == mado_pkg::ADDR_DEV_CTRL) fa = d[19:11];
	endtask
	task automatic upd();
		@(posedge CLK);
		rnd = nx(rnd);
		an <= rnd[14:0];
		cfg <= rnd[8:0];
		inst <= rnd[3:0];
		LOOP_UPDATE <= 1'b1;
		@(posedge CLK);
		LOOP_UPDATE <= 1'b0;
		lastexp = expv();
		q.push_back(lastexp);
		repeat (3) @(posedge CLK);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	always @(posedge CLK) begin
		lu1 <= LOOP_UPDATE;
		lu2 <= lu1;
	end
	always @(negedge CLK) begin
		if (lu2 === 1'b1) begin
			if (q.size() == 0) chk("queue", 42'h1, 42'h0);
			else chk("outputs", q.pop_front(), obs);
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [9:0] codes[8] = '{10'h000, 10'h1F4, 10'h1F5, 10'h1FF, 10'h200, 10'h3E8, 10'h3E9, 10'h3FF};
		logic [8:0] angs[3] = '{9'h1FF, 9'h168, 9'h0A5};
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		upd();
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			sm <= m[1:0];
			sde <= m[0];
			rnd = nx(rnd);
			w(EC, {m[0], rnd[14:0], 5'h1F, 11'h000});
			upd();
			w(EC, {~m[0], rnd[14:0], 16'h0000});
			upd();
		end
		$display("test holds done");
		w(EC, 32'h8000_8000);
		repeat (4) @(posedge CLK);
		chk("early apply", lastexp, obs);
		upd();
		$display("test deferred apply done");
		foreach (angs[i]) begin
			w(mado_pkg::ADDR_DEV_CTRL, {12'h000, angs[i], 11'h000});
			w(EC, 32'h0000_0400);
			upd();
		end
		w(EC, 32'h0000_0000);
		upd();
		$display("test angle done");
		off <= 1'b1;
		foreach (codes[i]) begin
			w(EC, {22'h000000, codes[i]}, 1);
			upd();
		end
		off <= 1'b0;
		upd();
		w(8'hEE, 32'hFFFF_FFFF, 1);
		upd();
		$display("test torque and unmapped done");
		for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge CLK);
		if (q.size() > 0) error_cnt++;
		tally_and_finish();
	end
endmodule // tb
